/* File: include/mapper_pkg.sv */
// Constants, register map and carrier types of the memory page window mapper.
// Assumes an APB slave with 32-bit data and registers on aligned words.
// Summary of operation
// - Control bit 7 shows scratch RAM.
// - Control bit 5 shows data flash info sector.
// - Control bit 4 maps program info sector.
// - Program page selects 16KB window at 0x8000.
// - Program page resets to 0xfe.
// - Local 0xc000-0xffff is always page 0xff.
// - Core page writes finish within instruction.
// - RAM page selects 4KB window at 0x1000.
// - RAM page zero reaches register space.
// - RAM page resets to 0xfd.
// - Local 0x2000/0x3000 fixed RAM pages 0xfe/0xff.
// - Small RAM leaves page 0xfd partly unimplemented.
// - Smaller RAM leaves fixed pages partly unimplemented.
// - Data flash page selects 1KB window.
// - Data flash page resets to 0xfe.
// - Local 0x0c00-0x0fff is data flash 0xff.
// - Normal single-chip: no external bus.
// - Special single-chip: debug unit runs core.
// - Core unimplemented access causes reset.
package mapper_pkg;
	// Register indices as printed; the byte address is four times the index.
	localparam logic [7:0] IDX_CTL = 8'h13;
	localparam logic [7:0] IDX_PGM_PAGE = 8'h15;
	localparam logic [7:0] IDX_RAM_PAGE = 8'h16;
	localparam logic [7:0] IDX_DF_PAGE = 8'h17;
	localparam logic [7:0] ADDR_CTL = 8'h4c;
	localparam logic [7:0] ADDR_PGM_PAGE = 8'h54;
	localparam logic [7:0] ADDR_RAM_PAGE = 8'h58;
	localparam logic [7:0] ADDR_DF_PAGE = 8'h5c;
	// Control field positions and the writable mask.
	localparam int BIT_SCRATCH = 7;
	localparam int BIT_DF_INFO = 5;
	localparam int BIT_PGM_INFO = 4;
	localparam logic [7:0] CTL_MASK = 8'hb0;
	// Reset values.
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] PGM_PAGE_RST = 8'hfe;
	localparam logic [7:0] RAM_PAGE_RST = 8'hfd;
	localparam logic [7:0] DF_PAGE_RST = 8'hfe;
	// Fixed page numbers of the unpaged regions.
	localparam logic [7:0] PAGE_FF = 8'hff;
	localparam logic [7:0] PAGE_FE = 8'hfe;
	localparam logic [7:0] PAGE_FD = 8'hfd;
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	// Global bases and limits.
	localparam logic [22:0] G_DF_BASE = 23'h10_0000;
	localparam logic [22:0] G_RAM_TOP = 23'h10_0000;
	localparam logic [22:0] G_FLASH_TOP = 23'h80_0000;
	localparam logic [22:0] G_PINFO_LO = 23'h40_0000;
	localparam logic [22:0] G_PINFO_HI = 23'h40_3fff;
	// Access target, one-hot.
	typedef enum logic [4:0] {
		T_REG = 5'h01,
		T_DFLASH = 5'h02,
		T_RAM = 5'h04,
		T_FLASH = 5'h08,
		T_UNIMPL = 5'h10
	} target_e;
	// Local access request from the core or the debug unit.
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic debug;
		logic firmware;
	} req_s;
	// Translated access.
	typedef struct packed {
		logic valid;
		target_e target;
		logic [22:0] gaddr;
		logic illegal;
		logic undefined;
	} res_s;
endpackage

/* File: rtl/page_window_mapper.sv */
// Page window mapper: paging and visibility registers and local-to-global translation.
// Assumes an APB master on CLK_IN and a mode pin from outside, synchronised here.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module page_window_mapper import mapper_pkg::*; #(
	parameter int RAM_BYTES = 12288,
	parameter int FLASH_BYTES = 262144,
	parameter int DFLASH_BYTES = 8192
) (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic CALL_PAGE_WR_IN,
	input wire logic [7:0] CALL_PAGE_DATA_IN,
	output logic [7:0] PROGRAM_PAGE_OUT,
	input wire req_s REQ_IN,
	output res_s RES_OUT,
	input wire logic MODE_SPECIAL_IN,
	output logic DEBUG_ACTIVE_OUT,
	output logic EXT_BUS_EN_OUT,
	output logic SCRATCH_RAM_VISIBLE_OUT,
	output logic DATA_FLASH_INFO_VISIBLE_OUT,
	output logic PROGRAM_FLASH_INFO_VISIBLE_OUT
);
	// Lowest implemented global address of RAM and of flash, and top of data flash.
	localparam logic [22:0] RAM_LOW = G_RAM_TOP - 23'(RAM_BYTES);
	localparam logic [22:0] FLASH_LOW = G_FLASH_TOP - 23'(FLASH_BYTES);
	localparam logic [22:0] DF_HIGH = G_DF_BASE + 23'(DFLASH_BYTES);

	// All state of the block in one record.
	typedef struct packed {
		logic [7:0] ctl;
		// Page indices, one byte each, each covering a full 256-page range.
		logic [7:0] pgm_page; // Program flash page of the 0x8000 window.
		logic [7:0] ram_page; // RAM page of the 0x1000 window.
		logic [7:0] df_page; // Data flash page of the 0x0800 window.
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic mode_meta;
		logic mode_sync;
		logic ext_bus;
		res_s res;
	} state_s;

	state_s state_q; // Registered state.
	state_s state_d; // Next state.

	// Translation and bus helpers, filled in the combinational process.
	logic [22:0] gaddr; // Global address of the current request.
	target_e target; // Target memory before the implemented-range check.
	logic unimpl; // Request lands in unimplemented space.
	logic setup; // APB setup phase.
	logic access; // APB access edge that completes a transfer.

	// Next-state process: bus slave, page registers and translation.
	always_comb begin
		state_d = state_q;
		gaddr = '0;
		target = T_REG;
		unimpl = 1'b0;
		setup = PSEL_IN & ~PENABLE_IN;
		access = PSEL_IN & PENABLE_IN & state_q.pready;

		// The mode pin is brought in through two flip-flops; only the second is used.
		state_d.mode_meta = MODE_SPECIAL_IN;
		state_d.mode_sync = state_q.mode_meta;
		// Neither single-chip mode has an external bus, so it stays off.
		state_d.ext_bus = 1'b0;

		// The setup phase prepares the answer; the access phase then lasts one cycle.
		state_d.pready = setup;
		if (setup) begin
			state_d.prdata = '0;
			state_d.pslverr = 1'b0;
			if (PADDR_IN == ADDR_CTL) begin
				state_d.prdata[7:0] = state_q.ctl;
			end else if (PADDR_IN == ADDR_PGM_PAGE) begin
				state_d.prdata[7:0] = state_q.pgm_page;
			end else if (PADDR_IN == ADDR_RAM_PAGE) begin
				state_d.prdata[7:0] = state_q.ram_page;
			end else if (PADDR_IN == ADDR_DF_PAGE) begin
				state_d.prdata[7:0] = state_q.df_page;
			end else begin
				// Unmapped words read zero and report an error.
				state_d.pslverr = 1'b1;
			end
		end

		// Writes take effect only at the access edge with ready high.
		if (access && PWRITE_IN) begin
			if (PADDR_IN == ADDR_CTL) begin
				// Bits other than the three visibility enables stay zero.
				state_d.ctl = PWDATA_IN[7:0] & CTL_MASK;
			end else if (PADDR_IN == ADDR_PGM_PAGE) begin
				// Page indices take all eight bits, so every page can be selected.
				state_d.pgm_page = PWDATA_IN[7:0];
			end else if (PADDR_IN == ADDR_RAM_PAGE) begin
				state_d.ram_page = PWDATA_IN[7:0];
			end else if (PADDR_IN == ADDR_DF_PAGE) begin
				state_d.df_page = PWDATA_IN[7:0];
			end
		end
		// The core's own page write wins over a bus write in the same cycle, and lands
		// at the next edge so the instruction sees it before it finishes.
		if (CALL_PAGE_WR_IN) begin
			state_d.pgm_page = CALL_PAGE_DATA_IN;
		end

		// Local-to-global translation, by local address region.
		// The regions are tested from the top down, so each test only needs the bits
		// that tell its region from the ones below it.
		// Flash lives in the upper half of the global map; its top bit marks it and the
		// page index supplies the next eight bits above the 16KB offset.
		if (REQ_IN.addr[15:14] == 2'b11) begin
			target = T_FLASH;
			gaddr = {1'b1, PAGE_FF, REQ_IN.addr[13:0]};
		end else if (REQ_IN.addr[15:14] == 2'b10) begin
			// Both masters share this window and its index.
			target = T_FLASH;
			gaddr = {1'b1, state_q.pgm_page, REQ_IN.addr[13:0]};
		end else if (REQ_IN.addr[15:14] == 2'b01) begin
			// With the reset page index this region makes flash linear up to 0xffff.
			target = T_FLASH;
			gaddr = {1'b1, PAGE_FD, REQ_IN.addr[13:0]};
		end else if (REQ_IN.addr[15:12] == 4'h3) begin
			target = T_RAM;
			gaddr = {3'b000, PAGE_FF, REQ_IN.addr[11:0]};
		end else if (REQ_IN.addr[15:12] == 4'h2) begin
			target = T_RAM;
			gaddr = {3'b000, PAGE_FE, REQ_IN.addr[11:0]};
		end else if (REQ_IN.addr[15:12] == 4'h1) begin
			// Page zero shares its global addresses with the register space.
			// This is the only region whose target follows the index, not the address.
			target = (state_q.ram_page == PAGE_ZERO) ? T_REG : T_RAM;
			gaddr = {3'b000, state_q.ram_page, REQ_IN.addr[11:0]};
		end else if (REQ_IN.addr[15:10] == 6'h03) begin
			target = T_DFLASH;
			gaddr = G_DF_BASE | {5'h00, PAGE_FF, REQ_IN.addr[9:0]};
		end else if (REQ_IN.addr[15:10] == 6'h02) begin
			target = T_DFLASH;
			// Data flash starts just above the RAM top, one kilobyte a page.
			gaddr = G_DF_BASE | {5'h00, state_q.df_page, REQ_IN.addr[9:0]};
		end else begin
			target = T_REG;
			gaddr = {7'h00, REQ_IN.addr};
		end

		// Space below implemented RAM and flash and above implemented data flash is unimplemented; the program information
		// sector fills the bottom of flash space only while its enable is set.
		if (target == T_RAM) begin
			unimpl = gaddr < RAM_LOW;
		end else if (target == T_FLASH) begin
			unimpl = (gaddr < FLASH_LOW) && !(state_q.ctl[BIT_PGM_INFO]
				&& gaddr >= G_PINFO_LO && gaddr <= G_PINFO_HI);
		end else if (target == T_DFLASH) begin
			unimpl = gaddr >= DF_HIGH;
		end

		// Translated access appears one cycle after the request. It is registered so that
		// the memories see a clean address; the price is one cycle of latency.
		state_d.res.valid = REQ_IN.valid;
		state_d.res.target = unimpl ? T_UNIMPL : target;
		state_d.res.gaddr = gaddr;
		// A core access to unimplemented space resets the chip; firmware commands and
		// the debug unit are exempt, the latter getting undefined data instead.
		state_d.res.illegal = REQ_IN.valid & unimpl & ~REQ_IN.debug & ~REQ_IN.firmware;
		state_d.res.undefined = REQ_IN.valid & unimpl & REQ_IN.debug;
	end

	// State register; reset loads constants only.
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_q <= '0;
			state_q.ctl <= CTL_RST;
			// Each page index leaves reset on the page that makes its region linear.
			state_q.pgm_page <= PGM_PAGE_RST;
			state_q.ram_page <= RAM_PAGE_RST;
			state_q.df_page <= DF_PAGE_RST;
			state_q.res.target <= T_REG;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs come straight from the state register.
	assign PRDATA_OUT = state_q.prdata;
	assign PREADY_OUT = state_q.pready;
	assign PSLVERR_OUT = state_q.pslverr;
	// The core reads its page index here directly, without a bus cycle.
	assign PROGRAM_PAGE_OUT = state_q.pgm_page;
	assign RES_OUT = state_q.res;
	// The debug unit runs the core while the special mode is strapped.
	assign DEBUG_ACTIVE_OUT = state_q.mode_sync;
	assign EXT_BUS_EN_OUT = state_q.ext_bus;
	assign SCRATCH_RAM_VISIBLE_OUT = state_q.ctl[BIT_SCRATCH];
	assign DATA_FLASH_INFO_VISIBLE_OUT = state_q.ctl[BIT_DF_INFO];
	assign PROGRAM_FLASH_INFO_VISIBLE_OUT = state_q.ctl[BIT_PGM_INFO];

	// Checks on the translation and on the registers.
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	// A completed bus write to a given word; a core page write in the same cycle is
	// left out because it overrides the bus.
	sequence s_wr(logic [7:0] a);
		PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == a && !CALL_PAGE_WR_IN;
	endsequence

	// A setup cycle is answered in the very next cycle.
	property p_ready_next;
		PSEL_IN && !PENABLE_IN |=> PREADY_OUT;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("register bus not answered");

	// Ready stands for the single access cycle only.
	property p_ready_pulse;
		PREADY_OUT |=> !PREADY_OUT;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	// Control writes land at the access edge.
	property p_ctl_write;
		s_wr(ADDR_CTL) |=> SCRATCH_RAM_VISIBLE_OUT == $past(PWDATA_IN[7])
			&& DATA_FLASH_INFO_VISIBLE_OUT == $past(PWDATA_IN[5]);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("visibility bits not written");

	// The program information sector enable follows its own write bit.
	property p_pgm_info_write;
		s_wr(ADDR_CTL) |=> PROGRAM_FLASH_INFO_VISIBLE_OUT == $past(PWDATA_IN[4]);
	endproperty
	a_pgm_info_write: assert property (p_pgm_info_write) else $error("info sector enable not written");

	// A RAM page write steers a window access made two cycles later.
	property p_ram_page_write;
		s_wr(ADDR_RAM_PAGE) ##2 REQ_IN.valid && REQ_IN.addr[15:12] == 4'h1
			|=> RES_OUT.gaddr[19:12] == $past(PWDATA_IN[7:0], 3);
	endproperty
	a_ram_page_write: assert property (p_ram_page_write) else $error("RAM window ignores page write");

	// A program page write over the bus lands at the access edge.
	property p_pgm_page_write;
		s_wr(ADDR_PGM_PAGE) |=> PROGRAM_PAGE_OUT == $past(PWDATA_IN[7:0]);
	endproperty
	a_pgm_page_write: assert property (p_pgm_page_write) else $error("program page not written");

	// Without a write of either kind the program page holds; this catches a stray
	// decode that would move the flash window under running code.
	property p_pgm_page_hold;
		!CALL_PAGE_WR_IN && !(PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
			&& PADDR_IN == ADDR_PGM_PAGE) |=> $stable(PROGRAM_PAGE_OUT);
	endproperty
	a_pgm_page_hold: assert property (p_pgm_page_hold) else $error("program page changed unasked");

	// The paged flash window uses the page index as it stood before the request.
	property p_flash_window;
		REQ_IN.valid && REQ_IN.addr[15:14] == 2'b10
			|=> RES_OUT.gaddr == {1'b1, $past(PROGRAM_PAGE_OUT), $past(REQ_IN.addr[13:0])};
	endproperty
	a_flash_window: assert property (p_flash_window) else $error("program window address wrong");

	// The top 16KB never moves.
	property p_fixed_flash;
		REQ_IN.valid && REQ_IN.addr[15:14] == 2'b11 |=> RES_OUT.gaddr[21:14] == PAGE_FF;
	endproperty
	a_fixed_flash: assert property (p_fixed_flash) else $error("fixed flash page wrong");

	// The region below the window stays on the page before the reset page.
	property p_linear_low;
		REQ_IN.valid && REQ_IN.addr[15:14] == 2'b01 |=> RES_OUT.gaddr[21:14] == PAGE_FD;
	endproperty
	a_linear_low: assert property (p_linear_low) else $error("low flash page wrong");

	// A paged call or return updates the page by the next edge.
	property p_call_write;
		CALL_PAGE_WR_IN |=> PROGRAM_PAGE_OUT == $past(CALL_PAGE_DATA_IN);
	endproperty
	a_call_write: assert property (p_call_write) else $error("core page write late");

	// The two upper RAM regions are fixed pages.
	property p_fixed_ram;
		REQ_IN.valid && REQ_IN.addr[15:13] == 3'b001
			|=> RES_OUT.gaddr[19:12] == ($past(REQ_IN.addr[12]) ? PAGE_FF : PAGE_FE);
	endproperty
	a_fixed_ram: assert property (p_fixed_ram) else $error("fixed RAM page wrong");

	// RAM page zero sends the window to the register space.
	property p_ram_zero;
		REQ_IN.valid && REQ_IN.addr[15:12] == 4'h1 && state_q.ram_page == PAGE_ZERO
			|=> RES_OUT.target == T_REG;
	endproperty
	a_ram_zero: assert property (p_ram_zero) else $error("RAM page zero not on registers");

	// The data flash window sits above the RAM top and follows its index.
	property p_df_window;
		REQ_IN.valid && REQ_IN.addr[15:10] == 6'h02
			|=> RES_OUT.gaddr[17:10] == $past(state_q.df_page) && RES_OUT.gaddr[20];
	endproperty
	a_df_window: assert property (p_df_window) else $error("data flash window wrong");

	// The upper data flash kilobyte is a fixed page.
	property p_fixed_df;
		REQ_IN.valid && REQ_IN.addr[15:10] == 6'h03 |=> RES_OUT.gaddr[17:10] == PAGE_FF;
	endproperty
	a_fixed_df: assert property (p_fixed_df) else $error("fixed data flash page wrong");

	// A reset request needs an unimplemented target and a core access.
	property p_illegal;
		RES_OUT.illegal |-> RES_OUT.target == T_UNIMPL && !RES_OUT.undefined;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal reset without cause");

	// Undefined data is only ever flagged for unimplemented space.
	property p_undefined;
		RES_OUT.undefined |-> RES_OUT.target == T_UNIMPL && !RES_OUT.illegal;
	endproperty
	a_undefined: assert property (p_undefined) else $error("undefined data without cause");

	// Every request is answered one cycle later.
	property p_res_follows;
		REQ_IN.valid |=> RES_OUT.valid;
	endproperty
	a_res_follows: assert property (p_res_follows) else $error("translation missing");

	// The external bus never comes on in either single-chip mode.
	property p_no_ext_bus;
		!EXT_BUS_EN_OUT [*8];
	endproperty
	a_no_ext_bus: assert property (p_no_ext_bus) else $error("external bus enabled");

	// A mode pin that stays high reaches the debug flag after the synchroniser.
	property p_mode_sync;
		$rose(MODE_SPECIAL_IN) ##1 MODE_SPECIAL_IN |=> DEBUG_ACTIVE_OUT;
	endproperty
	a_mode_sync: assert property (p_mode_sync) else $error("debug mode not followed");
endmodule

/* File: verif/core_master.sv */
// Partner model of the bus masters, that is the core and the debug unit.
// Assumes the mapper samples its request and page-write inputs on each rising edge.
`timescale 1ns/1ps
module core_master import mapper_pkg::*; (
	input wire logic clk_in,
	output req_s req_out,
	output logic page_wr_out,
	output logic [7:0] page_data_out
);
	// All outputs idle from time zero, so the mapper never sees unknowns.
	initial begin
		req_out = '0;
		page_wr_out = 1'b0;
		page_data_out = 8'h00;
	end
	// One request held for one cycle; m is {debug, firmware}.
	// On release the fields are inverted, so a stale value cannot pass for a held one.
	task automatic issue(input logic [15:0] a, input logic [1:0] m);
		@(posedge clk_in);
		req_out <= '{1'b1, a, m[1], m[0]};
		@(posedge clk_in);
		req_out <= '{1'b0, ~a, ~m[1], ~m[0]};
	endtask
	// Direct page write of a paged call or return, one cycle long.
	task automatic call_wr(input logic [7:0] p);
		@(posedge clk_in);
		page_wr_out <= 1'b1;
		page_data_out <= p;
		@(posedge clk_in);
		page_wr_out <= 1'b0;
		page_data_out <= ~p;
	endtask
endmodule

/* File: verif/tb_memory_page_window_mapper.sv */
// Self-checking bench of the page window mapper, with a table of translations.
// Assumes the mapper answers APB in one access cycle and translates one cycle after a request.
`timescale 1ns/1ps
module tb_memory_page_window_mapper import mapper_pkg::*;;
	typedef struct packed {logic [7:0] pp; logic [7:0] rp; logic [7:0] ep; logic [15:0] a;
		logic [1:0] m; target_e t; logic [22:0] g; logic [1:0] e;} row_s;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, mode = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, cwr, dbg, ext, v_s, v_d, v_p;
	logic [7:0] cdat, ppo;
	req_s req;
	res_s res;
	int n_fail = 0, comparisons = 0;
	// Smaller RAM, so the wholly unimplemented page 0xfd and the partly unimplemented fixed page 0xfe can be reached.
	row_s rows [16] = '{
		'{8'hfe,8'hfd,8'hfe,16'h8123,2'b00,T_FLASH,23'h7f8123,2'b00},
		'{8'h12,8'hfd,8'hfe,16'hbfff,2'b00,T_UNIMPL,23'h44bfff,2'b10},
		'{8'h12,8'hfd,8'hfe,16'hbfff,2'b10,T_UNIMPL,23'h44bfff,2'b01},
		'{8'h12,8'hfd,8'hfe,16'hbfff,2'b01,T_UNIMPL,23'h44bfff,2'b00},
		'{8'h12,8'hfd,8'hfe,16'hc000,2'b00,T_FLASH,23'h7fc000,2'b00},
		'{8'h12,8'hfd,8'hfe,16'h4000,2'b10,T_FLASH,23'h7f4000,2'b00},
		'{8'h00,8'hfd,8'hfe,16'h8010,2'b00,T_UNIMPL,23'h400010,2'b10},
		'{8'hfe,8'h00,8'hfe,16'h1234,2'b00,T_REG,23'h000234,2'b00},
		'{8'hfe,8'h80,8'hfe,16'h1000,2'b00,T_UNIMPL,23'h080000,2'b10},
		'{8'hfe,8'hfd,8'hfe,16'h1fff,2'b00,T_UNIMPL,23'h0fdfff,2'b10},
		'{8'hfe,8'h00,8'hfe,16'h2010,2'b00,T_UNIMPL,23'h0fe010,2'b10},
		'{8'hfe,8'h00,8'hfe,16'h2800,2'b00,T_RAM,23'h0fe800,2'b00},
		'{8'hfe,8'h00,8'hfe,16'h3ffe,2'b00,T_RAM,23'h0ffffe,2'b00},
		'{8'hfe,8'hfd,8'h05,16'h0800,2'b00,T_DFLASH,23'h101400,2'b00},
		'{8'hfe,8'hfd,8'h08,16'h0bff,2'b00,T_UNIMPL,23'h1023ff,2'b10},
		'{8'hfe,8'hfd,8'h05,16'h0c00,2'b10,T_UNIMPL,23'h13fc00,2'b01}};
	int bits [3] = '{7, 5, 4};
	page_window_mapper #(.RAM_BYTES(6144)) i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CALL_PAGE_WR_IN(cwr), .CALL_PAGE_DATA_IN(cdat),
		.PROGRAM_PAGE_OUT(ppo), .REQ_IN(req), .RES_OUT(res), .MODE_SPECIAL_IN(mode),
		.DEBUG_ACTIVE_OUT(dbg), .EXT_BUS_EN_OUT(ext), .SCRATCH_RAM_VISIBLE_OUT(v_s),
		.DATA_FLASH_INFO_VISIBLE_OUT(v_d), .PROGRAM_FLASH_INFO_VISIBLE_OUT(v_p));
	core_master i_master (.clk_in(clk), .req_out(req), .page_wr_out(cwr), .page_data_out(cdat));
	// 20 MHz clock.
	initial begin
		forever #25 clk = ~clk;
	end
	// Compare task for register and flag values.
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Compare task for one translation result.
	task automatic chk_res(input res_s e);
		comparisons++;
		if (res !== e) begin
			n_fail++;
			$display("wrong value at %0t: translation %h expected %h", $time, res, e);
		end
	endtask
	// One APB transfer; the request is held until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("wrong value at %0t: no ready from the register bus", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Reset for two cycles, then read every register and write one unmapped word.
	task automatic rst_chk();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_CTL, '0);
		chk({rd, err}, 33'h0);
		apb(1'b0, ADDR_PGM_PAGE, '0);
		chk(rd, 32'hfe);
		apb(1'b0, ADDR_RAM_PAGE, '0);
		chk(rd, 32'hfd);
		apb(1'b0, ADDR_DF_PAGE, '0);
		chk(rd, 32'hfe);
		apb(1'b1, 8'h50, 32'hff);
		chk({rd, err}, 33'h1);
		$display("test reset done");
	endtask
	// Closing task: counts, then the verdict.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hang is cut short well after the tests should have ended.
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim();
	end
	initial begin
		rst_chk();
		// Table: set the three pages, issue the access, check the answer.
		foreach (rows[i]) begin
			// RAM page goes last, so the request follows its write closely.
			apb(1'b1, ADDR_PGM_PAGE, {24'h0, rows[i].pp});
			apb(1'b1, ADDR_DF_PAGE, {24'h0, rows[i].ep});
			apb(1'b1, ADDR_RAM_PAGE, {24'h0, rows[i].rp});
			i_master.issue(rows[i].a, rows[i].m);
			#1 chk_res('{1'b1, rows[i].t, rows[i].g, rows[i].e[1], rows[i].e[0]});
		end
		$display("test table done");
		// Visibility bits: only 7, 5 and 4 are kept.
		apb(1'b1, ADDR_CTL, 32'hff);
		apb(1'b0, ADDR_CTL, '0);
		chk({rd, v_s, v_d, v_p}, {32'hb0, 3'b111});
		foreach (bits[i]) begin
			apb(1'b1, ADDR_CTL, 32'h1 << bits[i]);
			#1 chk({v_s, v_d, v_p}, 3'b100 >> i);
		end
		// With the program info sector shown its range becomes implemented.
		apb(1'b1, ADDR_PGM_PAGE, 32'h00);
		i_master.issue(16'h8010, 2'b00);
		#1 chk_res('{1'b1, T_FLASH, 23'h400010, 1'b0, 1'b0});
		$display("test visibility done");
		// Direct page write from a paged call, seen at once and over the bus.
		i_master.call_wr(8'h33);
		#1 chk(ppo, 32'h33);
		apb(1'b0, ADDR_PGM_PAGE, '0);
		chk(rd, 32'h33);
		// Mode pin reaches the debug flag after synchronisation; no external bus ever.
		mode <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({dbg, ext}, 2'b10);
		chk(ext, 32'h0);
		$display("test call and mode done");
		// Second reset in mid-run after every register was written.
		rst_chk();
		end_sim();
	end
endmodule
